// [autoreclose_defs.vh]
`ifndef AUTORECLOSE_DEFS_VH
`define AUTORECLOSE_DEFS_VH
// ==========================================
// timing
`define AR_CLK_MHZ        50
`define AR_MS_US          1000
`define AR_MS_CYCLES      (`AR_MS_US * `AR_CLK_MHZ)
// ==========================================
// register offsets
`define AR_CTRL           8'h00
`define AR_STATUS         8'h04
`define AR_INT_STATUS     8'h08
`define AR_INT_MASK       8'h0C
`define AR_PH_STEP        8'h10
`define AR_N_STEP         8'h14
`define AR_STEP_MEM       8'h18
`define AR_SEQ_RESET      8'h1C
`define AR_CMD            8'h20
`define AR_SHOT_BASE_HI   3'h2
// ==========================================
// field positions
`define AR_CTRL_EN        0
`define AR_CTRL_COORD     1
`define AR_CTRL_MAX_LO    2
`define AR_CTRL_MAX_HI    4
`define AR_CMD_CLR_LOCK   0
`define AR_SET_DEAD_HI    15
`define AR_SET_BLK_LO     16
`define AR_SET_BLK_HI     19
`define AR_SET_CRV_LO     20
`define AR_SET_CRV_HI     23
`define AR_EV_EXT         0
`define AR_EV_LOCK        1
`define AR_EV_CLOSE       2
`define AR_EV_RESET       3
// ==========================================
// reset values
`define AR_CTRL_RST       32'h0000_0010
`define AR_PH_STEP_RST    16'h0100
`define AR_N_STEP_RST     16'h0080
`define AR_STEP_MEM_RST   16'h0064
`define AR_SEQ_RESET_RST  16'h2710
`define AR_SHOTS          5
`endif

// [shot_settings_mem.v]
`timescale 1ns/1ps
`include "autoreclose_defs.vh"
// ==========================================
// per-shot settings store, entry 0 holds the initial settings
module shot_settings_mem (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        wr_en,
   input  wire [2:0]  wr_addr,
   input  wire [31:0] wr_data,
   input  wire [2:0]  bus_addr,
   output reg  [31:0] bus_data_r,
   input  wire [2:0]  seq_addr,
   output reg  [31:0] seq_data_r
);
   reg [31:0] mem_r [0:`AR_SHOTS-1];
   integer i;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < `AR_SHOTS; i = i + 1) begin
            mem_r[i] <= 32'h0000_0000;
         end
         bus_data_r <= 32'h0000_0000;
         seq_data_r <= 32'h0000_0000;
      end else begin
         if (wr_en && wr_addr < `AR_SHOTS) begin
            mem_r[wr_addr] <= wr_data;
         end
         bus_data_r <= (bus_addr < `AR_SHOTS) ? mem_r[bus_addr] : 32'h0000_0000;
         seq_data_r <= (seq_addr < `AR_SHOTS) ? mem_r[seq_addr] : 32'h0000_0000;
      end
   end
endmodule

// [autoreclose_zone_coordination.v]
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "autoreclose_defs.vh"
// Operation
// - with coordination on, a current rise then fall means an external reclose
// - external reclose bumps shot count, switches settings, starts reset timer
// - further external recloses keep counting; reaching the maximum forces lockout
// - transient faults clear only through the ordinary sequence reset timer
// - a rise counts only when at or above its phase or neutral threshold
// - a remembered rise is dropped when no fall comes within step memory time
// - shots one to four each hold dead time and overcurrent settings
// - settings of shots above the programmed maximum are never used
// - overcurrent elements reset when breaker feedback shows the breaker open
// - when reclose conditions are met, issue close and advance shot counter
// - active shot settings block selected instantaneous elements
// - trip with reclose initiate recloses below maximum, else goes to lockout
// - reset timer expiry outside lockout zeroes shot counter and restores initial settings
// - programmed maximum shot count is the reclosures attempted before lockout
module autoreclose_zone_coordination #(
   parameter MS_CYCLES = `AR_MS_CYCLES
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg  [31:0] hrdata,
   output wire        hresp,
   input  wire        meas_valid,
   input  wire [15:0] phase_mag,
   input  wire [15:0] neutral_mag,
   input  wire        trip_ar,
   input  wire        bkr_closed,
   output reg         close_cmd,
   output reg         oc_reset,
   output reg         lockout,
   output reg         in_progress,
   output reg  [2:0]  shot_count,
   output reg  [3:0]  inst_block,
   output reg  [3:0]  curve_sel,
   output reg         irq
);
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_WAIT = 2'd1;
   localparam [1:0] ST_DEAD = 2'd2;
   localparam [1:0] ST_LOCK = 2'd3;
   localparam [31:0] MS_LAST_W = MS_CYCLES - 1;
   localparam [15:0] MS_LAST = MS_LAST_W[15:0];

   reg  [31:0] ctrl_r;
   reg  [3:0]  int_sts_r;
   reg  [3:0]  int_mask_r;
   reg  [15:0] ph_thr_r;
   reg  [15:0] n_thr_r;
   reg  [15:0] step_mem_r;
   reg  [15:0] seq_delay_r;
   reg  [7:0]  addr_r;
   reg         wr_pend_r;
   reg         rd_pend_r;
   reg         bkr_s1_r;
   reg         bkr_s2_r;
   reg         bkr_prev_r;
   reg  [15:0] pre_r;
   reg  [1:0]  state_r;
   reg  [2:0]  shot_r;
   reg  [15:0] dead_cnt_r;
   reg         rst_run_r;
   reg  [15:0] rst_cnt_r;
   reg  [3:0]  evt_r;
   reg         use_r;
   reg         clr_lock_r;
   reg  [2:0]  seq_addr;
   wire        ms_tick;
   wire        ar_en;
   wire        coord_en;
   wire [2:0]  max_shots;
   wire [1:0]  fall_v;
   wire        ext_reclose;
   wire [31:0] mag_all;
   wire [31:0] thr_all;
   wire [31:0] bus_mem_data;
   wire [31:0] seq_data;
   wire        addr_ph;
   wire        mem_wr;
   wire [2:0]  next_shot;

   assign hresp     = 1'b0;
   assign ar_en     = ctrl_r[`AR_CTRL_EN];
   assign coord_en  = ctrl_r[`AR_CTRL_COORD];
   assign max_shots = ctrl_r[`AR_CTRL_MAX_HI:`AR_CTRL_MAX_LO];
   assign ms_tick   = (pre_r == MS_LAST);
   assign addr_ph   = hsel & htrans[1] & hready;
   assign mem_wr    = wr_pend_r & (addr_r[7:5] == `AR_SHOT_BASE_HI);
   assign mag_all   = {neutral_mag, phase_mag};
   assign thr_all   = {n_thr_r, ph_thr_r};
   assign ext_reclose = |fall_v;
   assign next_shot = shot_r + 3'd1;

   // ==========================================
   // settings store
   shot_settings_mem u_mem (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .wr_en      (mem_wr),
      .wr_addr    (addr_r[4:2]),
      .wr_data    (hwdata),
      .bus_addr   (haddr[4:2]),
      .bus_data_r (bus_mem_data),
      .seq_addr   (seq_addr),
      .seq_data_r (seq_data)
   );

   // shot being prepared while waiting for breaker open and during dead time, else active shot
   always @* begin
      if (state_r == ST_WAIT || state_r == ST_DEAD) begin
         seq_addr = next_shot;
      end else begin
         seq_addr = shot_r;
      end
      if (seq_addr > max_shots) begin
         seq_addr = 3'd0;
      end
   end

   // ==========================================
   // ahb-lite slave, writes zero wait, reads one wait
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r      <= 8'h00;
         wr_pend_r   <= 1'b0;
         rd_pend_r   <= 1'b0;
         hreadyout   <= 1'b1;
         hrdata      <= 32'h0000_0000;
         ctrl_r      <= `AR_CTRL_RST;
         int_mask_r  <= 4'h0;
         ph_thr_r    <= `AR_PH_STEP_RST;
         n_thr_r     <= `AR_N_STEP_RST;
         step_mem_r  <= `AR_STEP_MEM_RST;
         seq_delay_r <= `AR_SEQ_RESET_RST;
         clr_lock_r  <= 1'b0;
      end else begin
         clr_lock_r <= 1'b0;
         wr_pend_r  <= 1'b0;
         if (addr_ph) begin
            addr_r    <= haddr[7:0];
            wr_pend_r <= hwrite;
            if (!hwrite) begin
               rd_pend_r <= 1'b1;
               hreadyout <= 1'b0;
            end
         end
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            hreadyout <= 1'b1;
            if (addr_r[7:5] == `AR_SHOT_BASE_HI) begin
               hrdata <= bus_mem_data;
            end else begin
               case (addr_r)
                  `AR_CTRL:       hrdata <= ctrl_r;
                  `AR_STATUS:     hrdata <= {24'h000000, rst_run_r, state_r, lockout,
                                             1'b0, shot_r};
                  `AR_INT_STATUS: hrdata <= {28'h0000000, int_sts_r};
                  `AR_INT_MASK:   hrdata <= {28'h0000000, int_mask_r};
                  `AR_PH_STEP:    hrdata <= {16'h0000, ph_thr_r};
                  `AR_N_STEP:     hrdata <= {16'h0000, n_thr_r};
                  `AR_STEP_MEM:   hrdata <= {16'h0000, step_mem_r};
                  `AR_SEQ_RESET:  hrdata <= {16'h0000, seq_delay_r};
                  default:        hrdata <= 32'h0000_0000;
               endcase
            end
         end
         if (wr_pend_r) begin
            case (addr_r)
               `AR_CTRL:      ctrl_r <= {27'h0000000, hwdata[4:0]};
               `AR_INT_MASK:  int_mask_r <= hwdata[3:0];
               `AR_PH_STEP:   ph_thr_r <= hwdata[15:0];
               `AR_N_STEP:    n_thr_r <= hwdata[15:0];
               `AR_STEP_MEM:  step_mem_r <= hwdata[15:0];
               `AR_SEQ_RESET: seq_delay_r <= hwdata[15:0];
               `AR_CMD:       clr_lock_r <= hwdata[`AR_CMD_CLR_LOCK];
               default:       clr_lock_r <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================
   // interrupts, set wins over write-one-to-clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_sts_r <= 4'h0;
         irq       <= 1'b0;
      end else begin
         if (wr_pend_r && addr_r == `AR_INT_STATUS) begin
            int_sts_r <= (int_sts_r & ~hwdata[3:0]) | evt_r;
         end else begin
            int_sts_r <= int_sts_r | evt_r;
         end
         irq <= |(int_sts_r & int_mask_r);
      end
   end

   // ==========================================
   // breaker feedback and millisecond tick
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bkr_s1_r   <= 1'b0;
         bkr_s2_r   <= 1'b0;
         bkr_prev_r <= 1'b0;
         oc_reset   <= 1'b0;
         pre_r      <= 16'h0000;
      end else begin
         bkr_s1_r   <= bkr_closed;
         bkr_s2_r   <= bkr_s1_r;
         bkr_prev_r <= bkr_s2_r;
         oc_reset   <= bkr_prev_r & ~bkr_s2_r;
         pre_r      <= ms_tick ? 16'h0000 : pre_r + 16'h0001;
      end
   end

   // ==========================================
   // step detectors, phase and neutral
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : step
         reg  [15:0] prev_r;
         reg         armed_r;
         reg  [15:0] mem_cnt_r;
         wire [15:0] cur;
         wire [15:0] thr;
         wire        rise;
         wire        fall;
         assign cur  = mag_all[g*16 +: 16];
         assign thr  = thr_all[g*16 +: 16];
         assign rise = meas_valid & (cur > prev_r) & ((cur - prev_r) >= thr);
         assign fall = meas_valid & armed_r & (prev_r > cur) & ((prev_r - cur) >= thr);
         assign fall_v[g] = fall & coord_en;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               prev_r    <= 16'h0000;
               armed_r   <= 1'b0;
               mem_cnt_r <= 16'h0000;
            end else begin
               if (meas_valid) begin
                  prev_r <= cur;
               end
               if (!coord_en || ext_reclose) begin
                  armed_r <= 1'b0;
               end else if (rise) begin
                  armed_r   <= 1'b1;
                  mem_cnt_r <= 16'h0000;
               end else if (armed_r && ms_tick) begin
                  if (mem_cnt_r >= step_mem_r) begin
                     armed_r <= 1'b0;
                  end else begin
                     mem_cnt_r <= mem_cnt_r + 16'h0001;
                  end
               end
            end
         end
      end
   endgenerate

   // ==========================================
   // reclose sequencer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r    <= ST_IDLE;
         shot_r     <= 3'd0;
         dead_cnt_r <= 16'h0000;
         rst_run_r  <= 1'b0;
         rst_cnt_r  <= 16'h0000;
         evt_r      <= 4'h0;
         close_cmd  <= 1'b0;
      end else begin
         evt_r     <= 4'h0;
         close_cmd <= 1'b0;
         if (rst_run_r && ms_tick) begin
            if (rst_cnt_r >= seq_delay_r) begin
               rst_run_r <= 1'b0;
               if (state_r != ST_LOCK) begin
                  shot_r <= 3'd0;
                  state_r <= ST_IDLE;
                  evt_r[`AR_EV_RESET] <= 1'b1;
               end
            end else begin
               rst_cnt_r <= rst_cnt_r + 16'h0001;
            end
         end
         case (state_r)
            ST_IDLE: begin
               if (ar_en && trip_ar) begin
                  if (!rst_run_r) begin
                     rst_run_r <= 1'b1;
                     rst_cnt_r <= 16'h0000;
                  end
                  if (shot_r < max_shots) begin
                     state_r <= ST_WAIT;
                  end else begin
                     state_r <= ST_LOCK;
                     evt_r[`AR_EV_LOCK] <= 1'b1;
                  end
               end else if (ar_en && ext_reclose) begin
                  shot_r    <= next_shot;
                  rst_run_r <= 1'b1;
                  rst_cnt_r <= 16'h0000;
                  evt_r[`AR_EV_EXT] <= 1'b1;
                  if (next_shot >= max_shots) begin
                     state_r <= ST_LOCK;
                     evt_r[`AR_EV_LOCK] <= 1'b1;
                  end
               end
            end
            ST_WAIT: begin
               if (!bkr_s2_r) begin
                  state_r    <= ST_DEAD;
                  dead_cnt_r <= 16'h0000;
               end
            end
            ST_DEAD: begin
               if (bkr_s2_r) begin
                  state_r <= ST_IDLE;
               end else if (ms_tick) begin
                  // whole ticks only, so a dead time never ends early
                  if (dead_cnt_r >= seq_data[`AR_SET_DEAD_HI:0]) begin
                     close_cmd <= 1'b1;
                     shot_r    <= next_shot;
                     state_r   <= ST_IDLE;
                     evt_r[`AR_EV_CLOSE] <= 1'b1;
                  end else begin
                     dead_cnt_r <= dead_cnt_r + 16'h0001;
                  end
               end
            end
            ST_LOCK: begin
               if (clr_lock_r) begin
                  state_r   <= ST_IDLE;
                  shot_r    <= 3'd0;
                  rst_run_r <= 1'b0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // status and active settings outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lockout     <= 1'b0;
         in_progress <= 1'b0;
         shot_count  <= 3'd0;
         inst_block  <= 4'h0;
         curve_sel   <= 4'h0;
         use_r       <= 1'b0;
      end else begin
         lockout     <= (state_r == ST_LOCK);
         in_progress <= (state_r == ST_WAIT) || (state_r == ST_DEAD);
         shot_count  <= shot_r;
         use_r       <= (state_r == ST_IDLE) || (state_r == ST_LOCK);
         if (use_r) begin
            inst_block <= seq_data[`AR_SET_BLK_HI:`AR_SET_BLK_LO];
            curve_sel  <= seq_data[`AR_SET_CRV_HI:`AR_SET_CRV_LO];
         end
      end
   end
endmodule

// [autoreclose_props.sv]
`timescale 1ns/1ps
// ==========================================
// bus and sequencer checks
module autoreclose_props #(
   parameter MS_CYCLES = 10
) (
   input wire       hclk,
   input wire       hresetn,
   input wire       hsel,
   input wire [1:0] htrans,
   input wire       hwrite,
   input wire       hready,
   input wire       hreadyout,
   input wire       hresp,
   input wire       bkr_closed,
   input wire       close_cmd,
   input wire       oc_reset,
   input wire       lockout,
   input wire       in_progress,
   input wire [2:0] shot_count
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire req = hsel && htrans[1] && hready;
   sequence rd_wait;
      !hreadyout;
   endsequence
   sequence rd_done;
      hreadyout;
   endsequence
   // ==========================================
   // assertions
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("response not okay");
   read_wait_a: assert property (req && !hwrite |=> rd_wait ##1 rd_done)
      else $error("read wait state wrong");
   write_zero_a: assert property (req && hwrite |=> hreadyout)
      else $error("write stalled");
   close_pulse_a: assert property (close_cmd |=> !close_cmd)
      else $error("close longer than one cycle");
   close_shot_a: assert property (close_cmd |-> ##[0:3] shot_count != 3'h0)
      else $error("close without shot advance");
   close_lock_a: assert property (close_cmd |-> !lockout)
      else $error("close while locked out");
   ocr_open_a: assert property ($fell(bkr_closed) |-> ##[1:4] oc_reset)
      else $error("no overcurrent reset on open");
   ocr_closed_a: assert property (oc_reset |-> !bkr_closed)
      else $error("overcurrent reset with breaker closed");
   shot_step_a: assert property ($changed(shot_count) |->
      shot_count == $past(shot_count) + 3'h1 || shot_count == 3'h0)
      else $error("shot count jumped");
   shot_max_a: assert property (shot_count <= 3'h4)
      else $error("shot count above four");
   lock_idle_a: assert property (!(lockout && in_progress))
      else $error("reclose in progress during lockout");
endmodule

// [breaker_model.sv]
`timescale 1ns/1ps
// ==========================================
// feeder breaker with 52a feedback
module breaker_model (
   input  wire  hclk,
   input  wire  hresetn,
   input  wire  open_req,
   input  wire  close_cmd,
   input  wire  slow,
   output logic bkr_closed
);
   logic [1:0] act;
   int         cnt;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bkr_closed <= 1'b1;
         act <= 2'h0;
         cnt <= 0;
      end else if (act == 2'h0) begin
         if (open_req || close_cmd) begin
            act <= open_req ? 2'h1 : 2'h2;
            cnt <= slow ? 40 : 2;
         end
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end else begin
         bkr_closed <= (act == 2'h2);
         act <= 2'h0;
      end
   end
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "autoreclose_defs.vh"
// ==========================================
// top bench
module tb;
   localparam   MS = 10;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dp = 0;
   logic        meas_valid = 0, trip_ar = 0, open_req = 0, slow = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0;
   logic [15:0] ph = 0, nu = 0, pv, nv;
   logic [3:0]  blk [5], crv [5];
   logic [31:0] exq [$];
   wire         hreadyout, hresp, bkr_closed, close_cmd, oc_reset, lockout, in_progress, irq;
   wire  [31:0] hrdata;
   wire  [2:0]  shot_count;
   wire  [3:0]  inst_block, curve_sel;
   int          n_errors = 0, checks_done = 0, n_close = 0, n_ocr = 0, i;
   time         t_open = 0, t_close = 0;
   always #10 hclk = ~hclk;
   autoreclose_zone_coordination #(.MS_CYCLES(MS)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .meas_valid(meas_valid),
      .phase_mag(ph), .neutral_mag(nu), .trip_ar(trip_ar), .bkr_closed(bkr_closed),
      .close_cmd(close_cmd), .oc_reset(oc_reset), .lockout(lockout),
      .in_progress(in_progress), .shot_count(shot_count), .inst_block(inst_block),
      .curve_sel(curve_sel), .irq(irq));
   breaker_model BRK (.hclk(hclk), .hresetn(hresetn), .open_req(open_req),
      .close_cmd(close_cmd), .slow(slow), .bkr_closed(bkr_closed));
   // ==========================================
   // tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) exq.push_back(d);
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask
   task st(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask
   task meas(input logic [15:0] p, input logic [15:0] n);
      @(posedge hclk);
      meas_valid <= 1'b1;
      ph <= p;
      nu <= n;
      @(posedge hclk);
      meas_valid <= 1'b0;
      st(6);
   endtask
   task ext(input logic [15:0] dp_, input logic [15:0] dn);
      meas(pv, nv);
      meas(pv + dp_, nv + dn);
      meas(pv, nv);
      st(8);
   endtask
   task sets(input int n);
      chk(inst_block, blk[n]);
      chk(curve_sel, crv[n]);
   endtask
   task trip(input logic s, input logic op, input int d);
      @(posedge hclk);
      trip_ar <= 1'b1;
      open_req <= op;
      slow <= s;
      @(posedge hclk);
      trip_ar <= 1'b0;
      open_req <= 1'b0;
      for (i = 0; i < 600 && close_cmd !== 1'b1 && lockout !== 1'b1; i++) @(posedge hclk);
      st(60);
      if (d > 0) chk(t_close - t_open >= d * MS * 20 && t_close - t_open <= (d + 1) * MS * 20 + 100, 1);
   endtask
   // ==========================================
   // result watcher
   always @(posedge hclk) begin
      if (dp && hreadyout === 1'b1) chk(hrdata, exq.pop_front());
      if (hreadyout === 1'b1) dp = hsel && htrans[1] && !hwrite;
      if (close_cmd === 1'b1) n_close++;
      if (close_cmd === 1'b1) t_close = $time;
      if (oc_reset === 1'b1) n_ocr++;
      if ($fell(bkr_closed)) t_open = $time;
   end
   initial begin
      #400_000;
      n_errors++;
      end_of_test();
   end
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'h106C));
      for (i = 0; i < 5; i++) begin
         blk[i] = $urandom;
         crv[i] = $urandom;
      end
      pv = $urandom % 16'h4000;
      nv = $urandom % 16'h4000;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, `AR_CTRL, `AR_CTRL_RST);
      bus(0, `AR_PH_STEP, `AR_PH_STEP_RST);
      bus(0, `AR_N_STEP, `AR_N_STEP_RST);
      bus(0, `AR_STEP_MEM, `AR_STEP_MEM_RST);
      bus(0, `AR_SEQ_RESET, `AR_SEQ_RESET_RST);
      bus(0, 8'h30, 32'h0);
      bus(1, `AR_INT_MASK, 32'hF);
      bus(1, `AR_STEP_MEM, 32'd5); // step memory above recloser clearing time
      bus(1, `AR_SEQ_RESET, 32'd100);
      for (i = 0; i < 5; i++) bus(1, 8'(8'h40 + 4 * i), {8'h0, crv[i], blk[i], 16'(i)});
      trip(0, 0, 0);
      chk(n_close, 0);
      bus(1, `AR_CTRL, 32'h9);
      trip(1, 1, 1);
      chk(n_close, 1);
      chk(n_ocr, 1);
      chk(shot_count, 1);
      sets(1);
      trip(0, 1, 2);
      chk(n_close, 2);
      chk(shot_count, 2);
      sets(2);
      trip(0, 0, 0);
      chk(lockout, 1);
      chk(n_close, 2);
      chk(irq, 1);
      bus(0, `AR_INT_STATUS, 32'h6);
      st(1000);
      bus(1, `AR_INT_STATUS, 32'hF);
      bus(1, `AR_CMD, 32'h1);
      st(4);
      chk(irq, 0);
      chk(lockout, 0);
      chk(shot_count, 0);
      bus(1, `AR_CTRL, 32'hF);
      ext(16'h0100, 16'h0);
      chk(shot_count, 1);
      sets(1);
      bus(0, `AR_INT_STATUS, 32'h1);
      ext(16'h00FF, 16'h007F);
      chk(shot_count, 1);
      meas(pv + 16'h0100, nv);
      st(70);
      meas(pv, nv);
      st(8);
      chk(shot_count, 1);
      ext(16'h0, 16'h0080);
      chk(shot_count, 2);
      chk(lockout, 0);
      ext(16'h0100, 16'h0);
      chk(shot_count, 3);
      chk(lockout, 1);
      bus(1, `AR_CMD, 32'h1);
      bus(1, `AR_INT_STATUS, 32'hF);
      bus(1, `AR_INT_MASK, 32'h0);
      ext(16'h0100, 16'h0);
      st(900);
      chk(shot_count, 1);
      st(250);
      chk(shot_count, 0);
      sets(0);
      chk(irq, 0);
      bus(0, `AR_INT_STATUS, 32'h9);
      bus(1, `AR_INT_MASK, 32'h8);
      st(3);
      chk(irq, 1);
      bus(1, `AR_INT_STATUS, 32'h8);
      st(3);
      chk(irq, 0);
      st(4);
      end_of_test();
   end
endmodule
bind autoreclose_zone_coordination autoreclose_props #(.MS_CYCLES(MS_CYCLES)) PROPS (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .bkr_closed(bkr_closed),
   .close_cmd(close_cmd), .oc_reset(oc_reset), .lockout(lockout),
   .in_progress(in_progress), .shot_count(shot_count));
